// file: include/pmg_pkg.sv
// package for the ports module: register map, field layouts, reset values, carrier structs
package pmg_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PORT_A_INPUT_VALUE    = 8'h00;
   localparam logic [7:0] OFS_PORT_A_PIN_SELECT     = 8'h04;
   localparam logic [7:0] OFS_PORT_B_OUTPUT_VALUE   = 8'h08;
   localparam logic [7:0] OFS_PORT_B_PIN_SELECT     = 8'h0C;
   localparam logic [7:0] OFS_PORT_B_OUTPUT_ENABLE  = 8'h10;
   localparam logic [7:0] OFS_PORT_C_INPUT_VALUE    = 8'h14;
   localparam logic [7:0] OFS_PORT_C_OUTPUT_VALUE   = 8'h18;
   localparam logic [7:0] OFS_PORT_C_PIN_SELECT     = 8'h1C;
   localparam logic [7:0] OFS_PORT_C_OUTPUT_ENABLE  = 8'h20;
   localparam logic [7:0] OFS_EXTENSION_LATCH_MIRROR = 8'h24;
   localparam logic [7:0] OFS_PRINTER_PHASE_NEXT    = 8'h28;
   localparam logic [7:0] OFS_SCANNER_PHASE_NEXT    = 8'h2C;

   // ----------------------------------------------------------------
   // widths and field layout
   // ----------------------------------------------------------------
   localparam int PA_W    = 4;
   localparam int PB_W    = 12;
   localparam int PC_W    = 8;
   localparam int EXT_W   = 16;
   localparam int PH_W    = 4;
   localparam int PA_SEL_W = 2;
   localparam int PB_EN_BIT = 0;
   localparam int PC_SEL_LO = 2;
   localparam int SEL_UART_TX_EN = 0;
   localparam int SEL_UART_RX    = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [PA_SEL_W-1:0] RST_PA_SEL = 2'h0;
   localparam logic [PB_W-1:0]     RST_PB_OUT = 12'h000;
   localparam logic [PB_W-1:0]     RST_PB_SEL = 12'h000;
   localparam logic                RST_PB_EN  = 1'b0;
   localparam logic [PC_W-1:0]     RST_PC_OUT = 8'h00;
   localparam logic [PC_W-1:0]     RST_PC_SEL = 8'h00;
   localparam logic [PC_W-1:0]     RST_PC_EN  = 8'h00;
   localparam logic [EXT_W-1:0]    RST_EXT    = 16'h0000;
   localparam logic [PH_W-1:0]     RST_PHASE  = 4'h0;

   // axi response codes
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carrier structs
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [PB_W-1:0] pin_out;
      logic [PB_W-1:0] pin_oe_n;
   } pmg_port_b_s;

   typedef struct packed
   {
      logic [PC_W-1:0] pin_out;
      logic [PC_W-1:0] pin_oe_n;
   } pmg_port_c_s;

   typedef struct packed
   {
      logic [PH_W-1:0] printer_phase_pins;
      logic [PH_W-1:0] scanner_phase_pins;
   } pmg_motor_s;

endpackage : pmg_pkg

// file: rtl/pmg_ports.sv
// ports module: general purpose ports, extension latch mirror, stepper phase outputs
`timescale 1ns/1ps
module pmg_ports
   import pmg_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,

   // axi4-lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,

   // port a pins and sharing-module side
   input  wire logic [PA_W-1:0]   port_a_pin_in,
   output      logic [PA_W-1:0]   port_a_module_in,
   output      logic              uart_tx_enable_input,
   output      logic              uart_rx_input,

   // port b pins and sharing-module side
   input  wire logic [PB_W-1:0]   port_b_module_out,
   output      pmg_port_b_s       port_b_pins,

   // port c pins and sharing-module side
   input  wire logic [PC_W-1:0]   port_c_pin_in,
   input  wire logic [PC_W-1:0]   port_c_module_out,
   input  wire logic [PC_W-1:0]   port_c_module_oe,
   output      logic [PC_W-1:0]   port_c_module_in,
   output      pmg_port_c_s       port_c_pins,

   // extension latch
   output      logic [EXT_W-1:0]  ext_latch_data,
   output      logic              ext_latch_strobe,

   // stepper motors
   input  wire logic              printer_motor_irq,
   input  wire logic              scanner_motor_irq,
   output      pmg_motor_s        motor_pins
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // input synchronisers (two flip-flops each)
   // ----------------------------------------------------------------
   logic [PA_W-1:0] pa_meta;
   logic [PA_W-1:0] pa_sync;

   logic [PC_W-1:0] pc_meta;
   logic [PC_W-1:0] pc_sync;

   logic [1:0]      irq_meta;
   logic [1:0]      irq_sync;
   logic [1:0]      irq_prev;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pa_meta  <= '0;
         pa_sync  <= '0;
         pc_meta  <= '0;
         pc_sync  <= '0;
         irq_meta <= 2'h0;
         irq_sync <= 2'h0;
         irq_prev <= 2'h0;
      end
      else
      begin
         pa_meta  <= port_a_pin_in;
         pa_sync  <= pa_meta;

         pc_meta  <= port_c_pin_in;
         pc_sync  <= pc_meta;

         irq_meta <= {scanner_motor_irq, printer_motor_irq};
         irq_sync <= irq_meta;
         irq_prev <= irq_sync;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   logic       aw_held;
   logic [7:0] aw_addr;
   logic       w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire do_write  = aw_held && w_held && !s_axi_bvalid;
   wire aw_take   = s_axi_awvalid && s_axi_awready;
   wire w_take    = s_axi_wvalid && s_axi_wready;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   wire wr_pa_sel  = do_write && aw_addr == OFS_PORT_A_PIN_SELECT;
   wire wr_pb_out  = do_write && aw_addr == OFS_PORT_B_OUTPUT_VALUE;
   wire wr_pb_sel  = do_write && aw_addr == OFS_PORT_B_PIN_SELECT;
   wire wr_pb_en   = do_write && aw_addr == OFS_PORT_B_OUTPUT_ENABLE;
   wire wr_pc_out  = do_write && aw_addr == OFS_PORT_C_OUTPUT_VALUE;
   wire wr_pc_sel  = do_write && aw_addr == OFS_PORT_C_PIN_SELECT;
   wire wr_pc_en   = do_write && aw_addr == OFS_PORT_C_OUTPUT_ENABLE;
   wire wr_ext     = do_write && aw_addr == OFS_EXTENSION_LATCH_MIRROR;
   wire wr_pph     = do_write && aw_addr == OFS_PRINTER_PHASE_NEXT;
   wire wr_sph     = do_write && aw_addr == OFS_SCANNER_PHASE_NEXT;

   wire wr_ro      = aw_addr == OFS_PORT_A_INPUT_VALUE || aw_addr == OFS_PORT_C_INPUT_VALUE;
   wire wr_hit     = wr_pa_sel || wr_pb_out || wr_pb_sel || wr_pb_en || wr_pc_out || wr_pc_sel
                     || wr_pc_en || wr_ext || wr_pph || wr_sph;

   // byte-lane merge of the write data
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held      <= 1'b0;
         aw_addr      <= 8'h00;
         w_held       <= 1'b0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;

         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit || wr_ro) ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [PA_SEL_W-1:0] port_a_pin_select;
   logic [PB_W-1:0]     port_b_output_value;
   logic [PB_W-1:0]     port_b_pin_select;
   logic                port_b_output_enable;

   logic [PC_W-1:0]     port_c_output_value;
   logic [PC_W-1:0]     port_c_pin_select;
   logic [PC_W-1:0]     port_c_output_enable;

   logic [EXT_W-1:0]    extension_latch_mirror;
   logic [PH_W-1:0]     printer_phase_next;
   logic [PH_W-1:0]     scanner_phase_next;

   logic                ext_pulse;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction : merge

   wire [31:0] m_pa  = merge({30'h0, port_a_pin_select}, w_data, wmask);
   wire [31:0] m_pbo = merge({20'h0, port_b_output_value}, w_data, wmask);
   wire [31:0] m_pbs = merge({20'h0, port_b_pin_select}, w_data, wmask);
   wire [31:0] m_pbe = merge({31'h0, port_b_output_enable}, w_data, wmask);

   wire [31:0] m_pco = merge({24'h0, port_c_output_value}, w_data, wmask);
   wire [31:0] m_pcs = merge({24'h0, port_c_pin_select}, w_data, wmask);
   wire [31:0] m_pce = merge({24'h0, port_c_output_enable}, w_data, wmask);

   wire [31:0] m_ext = merge({16'h0, extension_latch_mirror}, w_data, wmask);
   wire [31:0] m_pph = merge({28'h0, printer_phase_next}, w_data, wmask);
   wire [31:0] m_sph = merge({28'h0, scanner_phase_next}, w_data, wmask);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_a_pin_select      <= RST_PA_SEL;
         port_b_output_value    <= RST_PB_OUT;
         port_b_pin_select      <= RST_PB_SEL;
         port_b_output_enable   <= RST_PB_EN;
         port_c_output_value    <= RST_PC_OUT;
         port_c_pin_select      <= RST_PC_SEL;
         port_c_output_enable   <= RST_PC_EN;
         extension_latch_mirror <= RST_EXT;
         printer_phase_next     <= RST_PHASE;
         scanner_phase_next     <= RST_PHASE;
         ext_pulse              <= 1'b0;
      end
      else
      begin
         ext_pulse <= wr_ext;

         if (wr_pa_sel) port_a_pin_select <= m_pa[PA_SEL_W-1:0];
         if (wr_pb_out) port_b_output_value <= m_pbo[PB_W-1:0];
         if (wr_pb_sel) port_b_pin_select <= m_pbs[PB_W-1:0];
         if (wr_pb_en) port_b_output_enable <= m_pbe[PB_EN_BIT];

         if (wr_pc_out) port_c_output_value <= m_pco[PC_W-1:0];
         if (wr_pc_sel) port_c_pin_select <= {m_pcs[PC_W-1:PC_SEL_LO], 2'b00};
         if (wr_pc_en) port_c_output_enable <= m_pce[PC_W-1:0];

         if (wr_ext) extension_latch_mirror <= m_ext[EXT_W-1:0];
         if (wr_pph) printer_phase_next <= m_pph[PH_W-1:0];
         if (wr_sph) scanner_phase_next <= m_sph[PH_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // extension latch: strobe while in reset and in the beat after a mirror write
   // ----------------------------------------------------------------
   assign ext_latch_data   = extension_latch_mirror;
   assign ext_latch_strobe = !rst_n || ext_pulse;

   // ----------------------------------------------------------------
   // stepper phase outputs, loaded on the synchronised interrupt rise
   // ----------------------------------------------------------------
   wire pm_rise = irq_sync[0] && !irq_prev[0];
   wire sm_rise = irq_sync[1] && !irq_prev[1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         motor_pins <= '0;
      else
      begin
         if (pm_rise) motor_pins.printer_phase_pins <= printer_phase_next;
         if (sm_rise) motor_pins.scanner_phase_pins <= scanner_phase_next;
      end
   end

   // ----------------------------------------------------------------
   // pin muxing
   // ----------------------------------------------------------------
   // port a: modules always see the synchronised pins; only the uart inputs need selecting, parked otherwise
   assign port_a_module_in = pa_sync;
   assign uart_tx_enable_input = port_a_pin_select[SEL_UART_TX_EN] && pa_sync[SEL_UART_TX_EN];
   assign uart_rx_input = !port_a_pin_select[SEL_UART_RX] || pa_sync[SEL_UART_RX];

   // port b: one enable for the whole port; modules drive when selected
   assign port_b_pins.pin_out  = (port_b_pin_select & port_b_module_out)
                                 | (~port_b_pin_select & port_b_output_value);
   assign port_b_pins.pin_oe_n = {PB_W{!port_b_output_enable}} & ~port_b_pin_select;

   // port c: per-pin enable; a selected pin follows the module both ways
   assign port_c_pins.pin_out  = (port_c_pin_select & port_c_module_out)
                                 | (~port_c_pin_select & port_c_output_value);
   assign port_c_pins.pin_oe_n = (port_c_pin_select & ~port_c_module_oe)
                                 | (~port_c_pin_select & ~port_c_output_enable);
   assign port_c_module_in     = pc_sync & port_c_pin_select;

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        rd_hit;

   always_comb
   begin
      rd_hit = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         OFS_PORT_A_INPUT_VALUE:     rd_mux = {28'h0, pa_sync};
         OFS_PORT_A_PIN_SELECT:      rd_mux = {30'h0, port_a_pin_select};
         OFS_PORT_B_OUTPUT_VALUE:    rd_mux = {20'h0, port_b_output_value};
         OFS_PORT_B_PIN_SELECT:      rd_mux = {20'h0, port_b_pin_select};
         OFS_PORT_B_OUTPUT_ENABLE:   rd_mux = {31'h0, port_b_output_enable};

         OFS_PORT_C_INPUT_VALUE:     rd_mux = {24'h0, pc_sync};
         OFS_PORT_C_OUTPUT_VALUE:    rd_mux = {24'h0, port_c_output_value};
         OFS_PORT_C_PIN_SELECT:      rd_mux = {24'h0, port_c_pin_select};
         OFS_PORT_C_OUTPUT_ENABLE:   rd_mux = {24'h0, port_c_output_enable};

         OFS_EXTENSION_LATCH_MIRROR: rd_mux = {16'h0, extension_latch_mirror};
         OFS_PRINTER_PHASE_NEXT:     rd_mux = {28'h0, printer_phase_next};
         OFS_SCANNER_PHASE_NEXT:     rd_mux = {28'h0, scanner_phase_next};
         default:
         begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= AXI_OKAY;
      end

      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule : pmg_ports

// file: verif/pmg_pins_model.sv
// far side: external output latch and the port c pin wires
`timescale 1ns/1ps
module pmg_pins_model
   import pmg_pkg::*;
(
   input  wire pmg_port_c_s       port_c_pins,
   input  wire logic [PC_W-1:0]   ext_drive,
   input  wire logic [EXT_W-1:0]  ext_latch_data,
   input  wire logic              ext_latch_strobe,
   output      logic [PC_W-1:0]   port_c_wire,
   output      logic [EXT_W-1:0]  latch_q
);
   // far device fills released pins
   assign port_c_wire = (port_c_pins.pin_out & ~port_c_pins.pin_oe_n) | (ext_drive & port_c_pins.pin_oe_n);

   // latch transparent while strobe high
   always_latch
      if (ext_latch_strobe)
         latch_q <= ext_latch_data;
endmodule : pmg_pins_model

// file: verif/pmg_ports_assertions.sv
// concurrent checks on the ports module pins and bus answers
`timescale 1ns/1ps
module pmg_ports_assertions
   import pmg_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             rstn,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [PA_W-1:0]  port_a_pin_in,
   input wire logic [PA_W-1:0]  port_a_module_in,
   input wire logic             uart_tx_enable_input,
   input wire logic             uart_rx_input,
   input wire pmg_port_b_s      port_b_pins,
   input wire pmg_port_c_s      port_c_pins,
   input wire logic [EXT_W-1:0] ext_latch_data,
   input wire logic             ext_latch_strobe,
   input wire logic             printer_motor_irq,
   input wire logic             scanner_motor_irq,
   input wire pmg_motor_s       motor_pins
);
   // ----------------------------------------------------------------
   // cycles since reset release, saturating
   // ----------------------------------------------------------------
   logic [2:0] up_cnt;
   logic       up;
   always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   assign up = (up_cnt == 3'h7);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   reset_outputs_a : assert property (disable iff (1'b0)
      !rstn |=> ext_latch_strobe && motor_pins == 8'h00 && port_b_pins.pin_oe_n == 12'hFFF
      && port_c_pins.pin_oe_n == 8'hFF) else $error("reset outputs");
   strobe_write_a : assert property (up && ext_latch_strobe |-> $rose(s_axi_bvalid))
      else $error("stray strobe");
   latch_data_a : assert property (up && !$stable(ext_latch_data) |-> ext_latch_strobe)
      else $error("data without strobe");
   bresp_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp moved");
   rdata_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata moved");
   tx_force_a : assert property (up && uart_tx_enable_input
      |-> $past(port_a_pin_in[0], 2) || $past(port_a_pin_in[0], 3)) else $error("tx not forced");
   rx_force_a : assert property (up && !uart_rx_input
      |-> !$past(port_a_pin_in[1], 2) || !$past(port_a_pin_in[1], 3)) else $error("rx not forced");
   port_a_follow_a : assert property (up && $past(port_a_pin_in, 2) == $past(port_a_pin_in, 3)
      |-> port_a_module_in == $past(port_a_pin_in, 2)) else $error("port a lost");
   printer_load_a : assert property (up && !$stable(motor_pins.printer_phase_pins)
      |-> $past(printer_motor_irq, 2)) else $error("printer phase early");
   scanner_load_a : assert property (up && !$stable(motor_pins.scanner_phase_pins)
      |-> $past(scanner_motor_irq, 2)) else $error("scanner phase early");

   cover property (up && ext_latch_strobe);
   cover property (up && !$stable(motor_pins));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : pmg_ports_assertions

// file: verif/tb_ports_module_gpio_motor_phase.sv
// testbench for the ports module
`timescale 1ns/1ps
module tb_ports_module_gpio_motor_phase
   import pmg_pkg::*;
;
   logic clk_sys = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, printer_motor_irq = 1'b0, scanner_motor_irq = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic uart_tx_enable_input, uart_rx_input, ext_latch_strobe;
   logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0]       s_axi_wstrb = 4'hF;
   logic [1:0]       s_axi_bresp, s_axi_rresp;
   logic [PA_W-1:0]  port_a_pin_in = 4'h0, port_a_module_in;
   logic [PB_W-1:0]  port_b_module_out = 12'h000;
   logic [PC_W-1:0]  port_c_pin_in, port_c_module_in, port_c_module_out = 8'h00, port_c_module_oe = 8'h00;
   logic [PC_W-1:0]  pc_ext = 8'h00;
   logic [EXT_W-1:0] ext_latch_data, latch_q;
   logic [33:0]      qe;
   logic [33:0]      expq[$];
   pmg_port_b_s      port_b_pins;
   pmg_port_c_s      port_c_pins;
   pmg_motor_s       motor_pins;
   int               fails = 0, total_checks = 0, cyc = 0, nstb = 0, n0;
   localparam logic [7:0] RW_OFS [10] = '{OFS_PORT_A_PIN_SELECT, OFS_PORT_B_OUTPUT_VALUE, OFS_PORT_B_PIN_SELECT,
      OFS_PORT_B_OUTPUT_ENABLE, OFS_PORT_C_OUTPUT_VALUE, OFS_PORT_C_PIN_SELECT, OFS_PORT_C_OUTPUT_ENABLE,
      OFS_EXTENSION_LATCH_MIRROR, OFS_PRINTER_PHASE_NEXT, OFS_SCANNER_PHASE_NEXT};
   localparam logic [31:0] RW_MSK [10] = '{32'h3, 32'hFFF, 32'hFFF, 32'h1, 32'hFF, 32'hFC, 32'hFF, 32'hFFFF,
      32'hF, 32'hF};

   pmg_ports dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pin_in, .port_a_module_in,
      .uart_tx_enable_input, .uart_rx_input, .port_b_module_out, .port_b_pins, .port_c_pin_in, .port_c_module_out,
      .port_c_module_oe, .port_c_module_in, .port_c_pins, .ext_latch_data, .ext_latch_strobe, .printer_motor_irq,
      .scanner_motor_irq, .motor_pins);
   pmg_pins_model u_far (.port_c_pins, .ext_drive(pc_ext), .ext_latch_data, .ext_latch_strobe,
      .port_c_wire(port_c_pin_in), .latch_q);

   always #12.5 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic cmp(input string nm, input logic [63:0] ex, input logic [63:0] got);
      total_checks++;
      if (got !== ex)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : cmp

   task automatic test_done;
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
      expq.push_back({r, 32'h0});
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
      expq.push_back({r, d});
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic chk_rst;
      @(negedge clk_sys);
      cmp("reset_out", {ext_latch_strobe, port_b_pins.pin_oe_n, port_c_pins.pin_oe_n, motor_pins},
         {1'b1, 12'hFFF, 8'hFF, 8'h00});
   endtask : chk_rst

   // ----------------------------------------------------------------
   // answer monitor and timeout
   // ----------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         test_done();
      end
      if (ext_latch_strobe && rstn)
         nstb++;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      begin
         qe = expq.pop_front();
         if (s_axi_rvalid)
            cmp("rdata", qe[31:0], s_axi_rdata);
         cmp("resp", qe[33:32], s_axi_rvalid ? s_axi_rresp : s_axi_bresp);
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h55E578DE));
      chk_rst();
      @(posedge clk_sys);
      rstn <= 1'b1;
      port_a_pin_in <= 4'($urandom);
      port_b_module_out <= 12'($urandom);
      port_c_module_out <= 8'($urandom);
      pc_ext <= 8'($urandom);
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 10; i++)
         rd(RW_OFS[i], 32'h0);
      rd(OFS_PORT_A_INPUT_VALUE, 32'(port_a_pin_in));
      wr(OFS_PORT_A_INPUT_VALUE, 32'hFFFFFFFF);
      rd(OFS_PORT_A_INPUT_VALUE, 32'(port_a_pin_in));
      rd(8'h30, 32'h0, AXI_SLVERR);
      wr(8'h30, 32'h1, AXI_SLVERR);
      for (int i = 0; i < 10; i++)
      begin
         v = $urandom;
         wr(RW_OFS[i], v);
         rd(RW_OFS[i], v & RW_MSK[i]);
      end
      n0 = nstb;
      v = $urandom;
      wr(OFS_EXTENSION_LATCH_MIRROR, v);
      rd(OFS_EXTENSION_LATCH_MIRROR, v & 32'hFFFF);
      cmp("latch", {n0 + 1, 16'(latch_q)}, {nstb, 16'(v)});
      wr(OFS_PORT_B_PIN_SELECT, 32'h0);
      wr(OFS_PORT_B_OUTPUT_ENABLE, 32'h0);
      wr(OFS_PORT_B_OUTPUT_VALUE, v);
      @(negedge clk_sys);
      cmp("pb_oe", port_b_pins.pin_oe_n, 12'hFFF);
      wr(OFS_PORT_B_OUTPUT_ENABLE, 32'h1);
      @(negedge clk_sys);
      cmp("pb_port", port_b_pins, {v[11:0], 12'h000});
      wr(OFS_PORT_B_PIN_SELECT, 32'hFFF);
      @(negedge clk_sys);
      cmp("pb_module", port_b_pins, {port_b_module_out, 12'h000});
      rd(OFS_PORT_B_OUTPUT_VALUE, v & 32'hFFF);
      wr(OFS_PORT_C_PIN_SELECT, 32'h0);
      wr(OFS_PORT_C_OUTPUT_VALUE, v);
      wr(OFS_PORT_C_OUTPUT_ENABLE, 32'hA5);
      repeat (4) @(posedge clk_sys);
      cmp("pc_oe", port_c_pins.pin_oe_n, 8'h5A);
      rd(OFS_PORT_C_INPUT_VALUE, 32'((v[7:0] & 8'hA5) | (pc_ext & 8'h5A)));
      port_c_module_oe <= 8'hFF;
      wr(OFS_PORT_C_OUTPUT_ENABLE, 32'h03);
      wr(OFS_PORT_C_PIN_SELECT, 32'hFC);
      repeat (4) @(posedge clk_sys);
      cmp("pc_module", port_c_pins, {(v[7:0] & 8'h03) | (port_c_module_out & 8'hFC), 8'h00});
      cmp("pc_in", port_c_module_in & 8'hFC, port_c_module_out & 8'hFC);
      port_a_pin_in <= 4'h1;
      wr(OFS_PORT_A_PIN_SELECT, 32'h0);
      repeat (4) @(posedge clk_sys);
      cmp("uart_forced", {uart_tx_enable_input, uart_rx_input}, 2'b01);
      wr(OFS_PORT_A_PIN_SELECT, 32'h3);
      repeat (4) @(posedge clk_sys);
      cmp("uart_pins", {uart_tx_enable_input, uart_rx_input}, 2'b10);
      wr(OFS_PRINTER_PHASE_NEXT, 32'hFA);
      wr(OFS_SCANNER_PHASE_NEXT, 32'h05);
      @(negedge clk_sys);
      cmp("motor_held", motor_pins, 8'h00);
      @(posedge clk_sys);
      printer_motor_irq <= 1'b1;
      repeat (8) @(posedge clk_sys);
      printer_motor_irq <= 1'b0;
      @(negedge clk_sys);
      cmp("motor_printer", motor_pins, 8'hA0);
      @(posedge clk_sys);
      scanner_motor_irq <= 1'b1;
      repeat (8) @(posedge clk_sys);
      scanner_motor_irq <= 1'b0;
      @(negedge clk_sys);
      cmp("motor_scanner", motor_pins, 8'hA5);
      @(posedge clk_sys);
      rstn <= 1'b0;
      chk_rst();
      @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(OFS_PORT_C_OUTPUT_ENABLE, 32'h0);
      test_done();
   end
endmodule : tb_ports_module_gpio_motor_phase

bind pmg_ports pmg_ports_assertions u_chk (.clk_sys, .rstn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_a_pin_in, .port_a_module_in, .uart_tx_enable_input,
   .uart_rx_input, .port_b_pins, .port_c_pins, .ext_latch_data, .ext_latch_strobe, .printer_motor_irq,
   .scanner_motor_irq, .motor_pins);
